//--- core/adc_scan_select_sequencer.sv
/*
  Scan/select sequencer for an eight-channel successive-approximation converter:
  control registers, phase timing, scan walk, select preemption and completion flags.
  Assumes the comparator delivers a ten-bit value on i_conv_value, valid at the end
  of the conversion phase, and a synchronous trigger input for scan start.
*/
`timescale 1ns/1ps
module adc_scan_select_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_write,
  input  wire logic        i_read,
  output logic      [15:0] o_rdata,
  // Trigger and power state
  input  wire logic        i_ext_trigger,
  input  wire logic        i_stop_mode,
  // Analog front end
  input  wire logic [9:0]  i_conv_value,
  output logic      [2:0]  o_mux_ch,
  output logic             o_sample,
  output logic             o_ref_enable,
  // Interrupt to the controller
  output logic             o_irq,
  output logic      [1:0]  o_irq_prio,
  output logic      [15:0] o_irq_vector
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]  ctrl_low;
    logic [7:0]  ctrl_high;
    logic [3:0]  irq_flags;
    logic        irq_req;
    logic        irq_en;
    logic [1:0]  prio;
    phase_t      phase;
    logic [9:0]  count;
    logic [2:0]  cur_ch;
    logic [2:0]  scan_ch;
    logic        in_select;
    logic        scan_armed;
    logic        trig_prev;
    logic        done_pend;
    logic        done_sel;
    logic        done_scan7;
    logic        rd_mem;
    logic [15:0] rd_reg;
    logic [15:0] rdata;
    logic [2:0]  mux_ch;
    logic        sample;
    logic        ref_en;
    logic        irq;
  } state_t;

  state_t st;
  state_t next_st;

  logic       mem_we;
  logic [9:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [9:0] phase_len(input phase_t ph, input logic [2:0] code);
    logic [9:0] len;
    len = 10'd1;
    unique case (ph)
      PH_SAMPLE: len = SAMPLE_CLKS[code];
      PH_CONV:   len = CONV_CLKS[code];
      PH_OTHER:  len = OTHER_CLKS[code];
      PH_IDLE:   len = 10'd1;
    endcase
    return len;
  endfunction

  function automatic logic [15:0] byte_word(input logic [7:0] b);
    return {8'h00, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [2:0] len_code;
  logic       wr_low;
  logic       wr_high;
  logic       wr_irq;
  logic       wr_sys;
  logic       scan_go;
  logic       sel_go;
  logic       trig_edge;
  logic       phase_end;

  always_comb begin
    next_st   = st;
    wr_low    = i_write && (i_addr == REG_CTRL_LOW);
    wr_high   = i_write && (i_addr == REG_CTRL_HIGH);
    wr_irq    = i_write && (i_addr == REG_IRQ_CTRL);
    wr_sys    = i_write && (i_addr == REG_IRQ_SYS);
    trig_edge = i_ext_trigger && !st.trig_prev;
    phase_end = (st.phase != PH_IDLE) && (st.count == 10'd1);
    mem_we    = 1'b0;

    next_st.trig_prev = i_ext_trigger;
    next_st.done_pend = 1'b0;

    // Register writes
    if (wr_low) begin
      next_st.ctrl_low = i_wdata[7:0] & 8'h77;
      if (i_wdata[SCAN_RUN_BIT] && !st.ctrl_low[SCAN_RUN_BIT]) begin
        next_st.scan_ch    = i_wdata[SCAN_CH_LSB +: 3];
        next_st.scan_armed = 1'b0;
      end
    end
    if (wr_high) begin
      next_st.ctrl_high = i_wdata[7:0] & 8'hF7;
    end
    // Taken after the write so a start and its length code may share one write
    len_code = next_st.ctrl_high[CONV_LEN_LSB +: 3];
    if (wr_sys) begin
      next_st.irq_req = i_wdata[IRQ_REQ_BIT];
      next_st.irq_en  = i_wdata[IRQ_EN_BIT];
      // Code 11 would be a fourth level; it is folded onto the highest of three
      next_st.prio    = (i_wdata[PRIO_LSB +: 2] == 2'b11) ? 2'b10
                                                          : i_wdata[PRIO_LSB +: 2];
    end

    // Scan trigger: software bit alone, or bit plus external edge
    scan_go = next_st.ctrl_low[SCAN_RUN_BIT] &&
              (!next_st.ctrl_low[SCAN_TRIG_BIT] || st.scan_armed || trig_edge);
    if (next_st.ctrl_low[SCAN_TRIG_BIT] && trig_edge && next_st.ctrl_low[SCAN_RUN_BIT]) begin
      next_st.scan_armed = 1'b1;
    end
    sel_go = next_st.ctrl_high[SEL_START_BIT];

    // Sequencer
    if (st.phase != PH_IDLE && st.in_select && !sel_go) begin
      next_st.phase = PH_IDLE;
    end else if (st.phase != PH_IDLE && !st.in_select && sel_go) begin
      next_st.in_select = 1'b1;
      next_st.cur_ch    = next_st.ctrl_high[SEL_CH_LSB +: 3];
      next_st.phase     = PH_SAMPLE;
      next_st.count     = phase_len(PH_SAMPLE, len_code);
    end else if (st.phase != PH_IDLE && !st.in_select && !scan_go) begin
      next_st.phase = PH_IDLE;
    end else if (phase_end) begin
      unique case (st.phase)
        PH_SAMPLE: begin
          next_st.phase = PH_CONV;
          next_st.count = phase_len(PH_CONV, len_code);
        end
        PH_CONV: begin
          next_st.phase = PH_OTHER;
          next_st.count = phase_len(PH_OTHER, len_code);
          mem_we        = 1'b1;
        end
        PH_OTHER: begin
          next_st.phase      = PH_IDLE;
          next_st.done_pend  = 1'b1;
          next_st.done_sel   = st.in_select;
          next_st.done_scan7 = !st.in_select && (st.cur_ch == LAST_CH);
          if (st.in_select) begin
            next_st.in_select = 1'b0;
          end else if (st.cur_ch == LAST_CH) begin
            next_st.scan_ch = st.ctrl_low[SCAN_CH_LSB +: 3];
          end else begin
            next_st.scan_ch = st.cur_ch + 3'h1;
          end
        end
        PH_IDLE: begin
          next_st.phase = PH_IDLE;
        end
      endcase
    end else if (st.phase != PH_IDLE) begin
      next_st.count = st.count - 10'd1;
    end else if (sel_go && !st.done_pend) begin
      next_st.in_select = 1'b1;
      next_st.cur_ch    = next_st.ctrl_high[SEL_CH_LSB +: 3];
      next_st.phase     = PH_SAMPLE;
      next_st.count     = phase_len(PH_SAMPLE, len_code);
    end else if (scan_go && !st.done_pend) begin
      next_st.in_select = 1'b0;
      next_st.cur_ch    = next_st.scan_ch;
      next_st.phase     = PH_SAMPLE;
      next_st.count     = phase_len(PH_SAMPLE, len_code);
    end

    // Software writes of the flags; a completion in the same cycle wins
    if (wr_irq) begin
      next_st.irq_flags = i_wdata[3:0];
    end
    if (st.done_pend) begin
      if (st.done_sel) begin
        next_st.irq_flags[SEL_DONE_BIT] = 1'b1;
        next_st.ctrl_high[SEL_START_BIT] = 1'b0;
        if (st.irq_flags[SEL_IE_BIT]) begin
          next_st.irq_req = 1'b1;
        end
      end else if (st.done_scan7) begin
        next_st.irq_flags[SCAN_DONE_BIT] = 1'b1;
        if (st.irq_flags[SCAN_IE_BIT]) begin
          next_st.irq_req = 1'b1;
        end
        if (!st.ctrl_low[SCAN_CONT_BIT]) begin
          next_st.ctrl_low[SCAN_RUN_BIT] = 1'b0;
          next_st.scan_ch = st.ctrl_low[SCAN_CH_LSB +: 3];
        end
      end
      next_st.scan_armed = next_st.scan_armed && next_st.ctrl_low[SCAN_RUN_BIT];
    end

    // Read data, one cycle after the strobe
    next_st.rd_mem = i_read && i_addr[3];
    unique case (i_addr)
      REG_CTRL_LOW:  next_st.rd_reg = byte_word(st.ctrl_low);
      REG_CTRL_HIGH: next_st.rd_reg = byte_word(st.ctrl_high);
      REG_IRQ_CTRL:  next_st.rd_reg = byte_word(IRQ_CTRL_FIXED | {4'h0, st.irq_flags});
      REG_IRQ_SYS:   next_st.rd_reg = byte_word({4'h0, st.prio, st.irq_en, st.irq_req});
      REG_STATUS:    next_st.rd_reg = {8'h00, st.in_select, st.cur_ch, 2'b00, st.phase};
      default:       next_st.rd_reg = 16'h0000;
    endcase
    if (!i_read) begin
      next_st.rd_reg = 16'h0000;
    end
    next_st.rdata = 16'h0000;

    // Front end and interrupt outputs
    next_st.mux_ch = next_st.cur_ch;
    next_st.sample = (next_st.phase == PH_SAMPLE);
    next_st.ref_en = (next_st.phase != PH_IDLE) && !i_stop_mode;
    next_st.irq    = next_st.irq_req && next_st.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st           <= '0;
      st.ctrl_low  <= CTRL_LOW_RESET;
      st.ctrl_high <= CTRL_HIGH_RESET;
      st.irq_flags <= IRQ_CTRL_RESET[3:0];
      st.phase     <= PH_IDLE;
      st.count     <= 10'd1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result store

  // Results are written at the end of the conversion phase, well before the flag
  adc_result_mem u_results (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (st.cur_ch),
    .i_wdata (i_conv_value),
    .i_raddr (i_addr[2:0]),
    .o_rdata (mem_rdata)
  );

  // Read data mux on registered sources only
  always_comb begin
    o_rdata = st.rd_mem ? {6'h00, mem_rdata} : st.rd_reg;
  end

  assign o_mux_ch     = st.mux_ch;
  assign o_sample     = st.sample;
  assign o_ref_enable = st.ref_en;
  assign o_irq        = st.irq;
  assign o_irq_prio   = st.prio;
  assign o_irq_vector = IRQ_VECTOR;

endmodule

//--- core/adc_seq_pkg.sv
/*
  Constants for the converter scan/select sequencer: register indices, field positions,
  reset values, conversion phase lengths and the shared interrupt vector.
  Assumes a plain address/strobe register port with 16-bit data.
*/
package adc_seq_pkg;

  // Register indices on the plain port
  localparam logic [3:0] REG_CTRL_LOW  = 4'h0;
  localparam logic [3:0] REG_CTRL_HIGH = 4'h1;
  localparam logic [3:0] REG_IRQ_CTRL  = 4'h2;
  localparam logic [3:0] REG_IRQ_SYS   = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_RESULT0   = 4'h8;

  // Lower control byte fields
  localparam int SCAN_CH_LSB   = 0;
  localparam int SCAN_RUN_BIT  = 4;
  localparam int SCAN_TRIG_BIT = 5;
  localparam int SCAN_CONT_BIT = 6;

  // Upper control byte fields
  localparam int SEL_CH_LSB    = 0;
  localparam int SEL_START_BIT = 4;
  localparam int CONV_LEN_LSB  = 5;

  // Interrupt control fields
  localparam int SCAN_DONE_BIT = 0;
  localparam int SEL_DONE_BIT  = 1;
  localparam int SCAN_IE_BIT   = 2;
  localparam int SEL_IE_BIT    = 3;

  // System interrupt register: request flag, enable, two priority bits
  localparam int IRQ_REQ_BIT   = 0;
  localparam int IRQ_EN_BIT    = 1;
  localparam int PRIO_LSB      = 2;

  // Reset values; upper nibble of interrupt control reads as ones
  localparam logic [7:0] CTRL_LOW_RESET  = 8'h00;
  localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RESET  = 8'hF0;
  localparam logic [7:0] IRQ_CTRL_FIXED  = 8'hF0;

  localparam logic [15:0] IRQ_VECTOR = 16'h0044;
  localparam logic [2:0]  LAST_CH    = 3'h7;

  // Sampling, conversion and overhead clocks per length code 0..7
  localparam logic [9:0] SAMPLE_CLKS [8] = '{10'd935, 10'd623, 10'd467, 10'd311,
                                             10'd233, 10'd155, 10'd116, 10'd77};
  localparam logic [9:0] CONV_CLKS [8]   = '{10'd314, 10'd210, 10'd158, 10'd106,
                                             10'd80, 10'd54, 10'd41, 10'd28};
  localparam logic [9:0] OTHER_CLKS [8]  = '{10'd287, 10'd191, 10'd143, 10'd95,
                                             10'd71, 10'd47, 10'd35, 10'd23};

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_CONV   = 2'b10,
    PH_OTHER  = 2'b11
  } phase_t;

endpackage

//--- core/adc_result_mem.sv
/*
  Eight ten-bit conversion result words with a registered read port.
  Assumes one write port from the sequencer and one read port from the register decode.
*/
`timescale 1ns/1ps
module adc_result_mem (
  // Clock
  input  wire logic       i_clk,
  // Write side
  input  wire logic       i_we,
  input  wire logic [2:0] i_waddr,
  input  wire logic [9:0] i_wdata,
  // Read side
  input  wire logic [2:0] i_raddr,
  output logic      [9:0] o_rdata
);

  // Contents are undefined after reset, so no reset on the array
  logic [9:0] mem [8];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

//--- tb/adc_seq_asserts.sv
/*
  Port-level checker for the scan/select sequencer, bound to its top module.
  Assumes the plain register port and one clock with synchronous reset.
*/
`timescale 1ns/1ps
module adc_seq_asserts
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // Register port
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_write,
  input wire logic        i_read,
  input wire logic [15:0] o_rdata,
  // Power, front end, interrupt
  input wire logic        i_stop_mode,
  input wire logic [2:0]  o_mux_ch,
  input wire logic        o_sample,
  input wire logic        o_ref_enable,
  input wire logic [1:0]  o_irq_prio,
  input wire logic [15:0] o_irq_vector
);
  logic [9:0] samp_cnt;
  logic [2:0] len_code;
  logic       cut;

  ////////////////////////////////////////////////////////////////////////////////
  // A write or stop during sampling may legally cut the phase short
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      samp_cnt <= 10'h000;
      len_code <= 3'h0;
      cut      <= 1'b0;
    end else begin
      samp_cnt <= o_sample ? samp_cnt + 10'h001 : 10'h000;
      if (i_write && i_addr == REG_CTRL_HIGH) begin
        len_code <= i_wdata[7:5];
      end
      if (!o_sample) begin
        cut <= 1'b0;
      end else if (i_write || i_stop_mode) begin
        cut <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_sample_len: assert property ($fell(o_sample) && !cut |-> samp_cnt == SAMPLE_CLKS[len_code])
    else $error("sampling phase length wrong");
  a_mux_stable: assert property (o_sample && $past(o_sample) && !cut |-> $stable(o_mux_ch))
    else $error("channel changed during sampling");
  a_sample_ref: assert property (o_sample && !i_stop_mode && !$past(i_stop_mode) |-> o_ref_enable)
    else $error("reference off while sampling");
  a_stop_ref: assert property (i_stop_mode |=> !o_ref_enable)
    else $error("reference on in stop mode");
  a_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_result_width: assert property (i_read && i_addr[3] |=> o_rdata[15:10] == 6'h00)
    else $error("result wider than ten bits");
  a_irqctrl_upper: assert property (i_read && i_addr == REG_IRQ_CTRL |=> o_rdata[7:4] == 4'hF)
    else $error("upper interrupt control bits not ones");
  a_prio_write: assert property (i_write && i_addr == REG_IRQ_SYS |=> o_irq_prio ==
    (($past(i_wdata[3:2]) == 2'b11) ? 2'b10 : $past(i_wdata[3:2])))
    else $error("priority not taken from write");
  a_prio_range: assert property (o_irq_prio != 2'b11)
    else $error("fourth priority level seen");
  a_vector_const: assert property (o_irq_vector == 16'h0044)
    else $error("interrupt vector wrong");
endmodule

bind adc_scan_select_sequencer adc_seq_asserts chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
  .i_read(i_read), .o_rdata(o_rdata), .i_stop_mode(i_stop_mode), .o_mux_ch(o_mux_ch),
  .o_sample(o_sample), .o_ref_enable(o_ref_enable), .o_irq_prio(o_irq_prio),
  .o_irq_vector(o_irq_vector)
);

//--- tb/adc_front_model.sv
/*
  Behavioural analog front end: a per-channel value derived from a base word.
  Assumes the sequencer samples the value late in the conversion phase.
*/
`timescale 1ns/1ps
module adc_front_model (
  // Clock
  input  wire logic       i_clk,
  // From the sequencer, and the base word from the bench
  input  wire logic [2:0] i_mux_ch,
  input  wire logic       i_ref_enable,
  input  wire logic [9:0] i_base,
  // To the sequencer
  output logic      [9:0] o_value
);
  initial o_value = 10'h155;
  // Without reference current the value is junk, so it churns every cycle
  always @(posedge i_clk) begin
    if (i_ref_enable) begin
      o_value <= i_base ^ {7'h00, i_mux_ch};
    end else begin
      o_value <= ~o_value;
    end
  end
endmodule

//--- tb/adc_scan_select_sequencer_tb.sv
/*
  Self-checking bench: register port tasks, expectation queues and output monitors.
  Assumes the front-end model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module adc_scan_select_sequencer_tb
  import adc_seq_pkg::*;
;
  logic        i_clk, i_reset, i_write, i_read, i_ext_trigger, i_stop_mode, en, rd_d, prev_s;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, o_irq_vector, ex;
  logic [9:0]  i_conv_value, base;
  logic [2:0]  o_mux_ch, ch, ce, prev_c;
  logic        o_sample, o_ref_enable, o_irq;
  logic [1:0]  o_irq_prio;
  logic [15:0] rd_e[$];
  string       rd_n[$], nm;
  logic [2:0]  ch_q[$];
  int          seed = 25736;
  int          checks, error_cnt, s_len, last_len;

  adc_scan_select_sequencer dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_ext_trigger(i_ext_trigger), .i_stop_mode(i_stop_mode), .i_conv_value(i_conv_value),
    .o_mux_ch(o_mux_ch), .o_sample(o_sample), .o_ref_enable(o_ref_enable), .o_irq(o_irq),
    .o_irq_prio(o_irq_prio), .o_irq_vector(o_irq_vector));
  adc_front_model front (.i_clk(i_clk), .i_mux_ch(o_mux_ch), .i_ref_enable(o_ref_enable),
    .i_base(base), .o_value(i_conv_value));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_write <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge i_clk);
    i_read <= 1'b1; i_addr <= a; rd_e.push_back(e); rd_n.push_back(n);
    @(posedge i_clk);
    i_read <= 1'b0;
  endtask
  // Bounded waits so a stuck sequencer shows up as a mismatch, not a hang
  task automatic wait_ref(input logic lvl);
    int n;
    n = 0;
    while (o_ref_enable !== lvl && n < 3000) begin @(negedge i_clk); n++; end
    `CHK("ref_wait", 1'b1, n < 3000)
  endtask
  task automatic wait_q();
    int n;
    n = 0;
    while (ch_q.size() != 0 && n < 3000) begin @(negedge i_clk); n++; end
    `CHK("ch_wait", 1'b1, n < 3000)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitors sample mid-cycle where registered outputs have settled
  always @(posedge i_clk) rd_d <= i_read;
  always @(negedge i_clk) begin
    if (rd_d) begin nm = rd_n.pop_front(); ex = rd_e.pop_front(); `CHK(nm, ex, o_rdata) end
    // A preempting select restarts sampling without a gap, seen as a channel change
    if (o_sample && (!prev_s || o_mux_ch !== prev_c)) begin
      if (ch_q.size() == 0) `CHK("extra_sample", 1'b0, 1'b1)
      else begin ce = ch_q.pop_front(); `CHK("mux_ch", ce, o_mux_ch) end
      s_len = 0;
    end
    if (o_sample) s_len++;
    else if (prev_s) last_len = s_len;
    prev_s = o_sample;
    prev_c = o_mux_ch;
  end
  initial begin i_clk = 1'b0; forever #10 i_clk = ~i_clk; end
  initial begin repeat (40000) @(posedge i_clk); error_cnt++; end_of_test(); end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset = 1'b1; i_write = 1'b0; i_read = 1'b0; i_addr = 4'h0; i_wdata = 16'h0000;
    i_ext_trigger = 1'b0; i_stop_mode = 1'b0; base = 10'h000; rd_d = 1'b0; prev_s = 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(REG_CTRL_LOW, 16'h0000, "ctrl_low");
    rd(REG_CTRL_HIGH, 16'h0000, "ctrl_high");
    rd(REG_IRQ_CTRL, 16'h00F0, "irq_ctrl");
    rd(REG_IRQ_SYS, 16'h0000, "irq_sys");
    rd(4'h5, 16'h0000, "unmapped");
    `CHK("vector", 16'h0044, o_irq_vector)
    for (int p = 0; p < 4; p++) begin
      wr(REG_IRQ_SYS, {12'h000, p[1:0], 2'b10});
      @(negedge i_clk);
      `CHK("prio", (p == 3) ? 2'b10 : p[1:0], o_irq_prio)
    end
    // Every length code once, interrupt enables alternating, random channel and data
    for (int c = 0; c < 8; c++) begin
      ch = 3'($random(seed)); base = 10'($random(seed)); en = ~c[0];
      wr(REG_IRQ_SYS, {14'h0000, en, 1'b0});
      i_ext_trigger <= 1'($random(seed));
      wr(REG_IRQ_CTRL, {12'h000, en, 3'b000});
      ch_q.push_back(ch);
      wr(REG_CTRL_HIGH, {8'h00, c[2:0], 2'b10, ch});
      wait_ref(1'b1); wait_ref(1'b0); repeat (6) @(negedge i_clk);
      `CHK("sample_len", SAMPLE_CLKS[c], last_len)
      `CHK("irq", en, o_irq)
      rd({1'b1, ch}, {6'h00, base ^ {7'h00, ch}}, "result");
      rd(REG_IRQ_CTRL, {12'h00F, en, 3'b010}, "irq_ctrl");
      rd(REG_CTRL_HIGH, {8'h00, c[2:0], 2'b00, ch}, "ctrl_high");
      rd(REG_IRQ_SYS, {14'h0000, en, en}, "irq_sys");
    end
    i_ext_trigger <= 1'b0;
    // One-shot scan from channel 5, preempted by select on channel 1
    base = 10'($random(seed));
    wr(REG_IRQ_SYS, 16'h0002);
    wr(REG_IRQ_CTRL, 16'h0004);
    wr(REG_CTRL_HIGH, 16'h00E1);
    ch_q.push_back(3'h5); ch_q.push_back(3'h6);
    wr(REG_CTRL_LOW, 16'h0015);
    wait_q(); repeat (10) @(posedge i_clk);
    ch_q.push_back(3'h1); ch_q.push_back(3'h6); ch_q.push_back(3'h7);
    wr(REG_CTRL_HIGH, 16'h00F1);
    wait_q(); wait_ref(1'b0); repeat (6) @(negedge i_clk);
    `CHK("scan_irq", 1'b1, o_irq)
    rd(REG_CTRL_LOW, 16'h0005, "ctrl_low");
    rd(REG_IRQ_CTRL, 16'h00F7, "irq_ctrl");
    rd(4'hF, {6'h00, base ^ 10'h007}, "result7");
    rd(4'h9, {6'h00, base ^ 10'h001}, "result1");
    // Repeating scan from channel 6, aborted after the wrap
    wr(REG_IRQ_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) ch_q.push_back(3'h6 + k[0]);
    wr(REG_CTRL_LOW, 16'h0056);
    wait_q(); repeat (5) @(posedge i_clk);
    wr(REG_CTRL_LOW, 16'h0046);
    repeat (4) @(negedge i_clk);
    `CHK("abort_ref", 1'b0, o_ref_enable)
    rd(REG_CTRL_LOW, 16'h0046, "ctrl_low");
    rd(REG_IRQ_CTRL, 16'h00F1, "irq_ctrl");
    // External trigger: nothing until the rising edge
    base = 10'($random(seed));
    wr(REG_CTRL_LOW, 16'h0037);
    repeat (10) @(negedge i_clk);
    `CHK("trig_wait", 1'b0, o_ref_enable)
    ch_q.push_back(3'h7);
    @(posedge i_clk) i_ext_trigger <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_ext_trigger <= 1'b0;
    wait_ref(1'b1); wait_ref(1'b0); repeat (6) @(negedge i_clk);
    wr(4'hF, 16'h03FF);
    rd(4'hF, {6'h00, base ^ 10'h007}, "result7");
    rd(REG_CTRL_LOW, 16'h0027, "ctrl_low");
    // Stop mode early in the sampling phase of a select conversion, then abort it
    ch_q.push_back(3'h3);
    wr(REG_CTRL_HIGH, 16'h00F3);
    @(posedge i_clk) i_stop_mode <= 1'b1;
    repeat (3) @(negedge i_clk);
    `CHK("stop_ref", 1'b0, o_ref_enable)
    @(posedge i_clk) i_stop_mode <= 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK("resume_ref", 1'b1, o_ref_enable)
    wr(REG_CTRL_HIGH, 16'h00E3);
    repeat (3) @(negedge i_clk);
    `CHK("sel_abort_ref", 1'b0, o_ref_enable)
    rd(REG_IRQ_CTRL, 16'h00F1, "irq_ctrl");
    `CHK("queue_left", 0, ch_q.size())
    repeat (4) @(posedge i_clk);
    end_of_test();
  end
endmodule
